// ===== pg_boot_pkg.sv
// Purpose: shared constants and carrier types for the power-good monitor
// Assumes: 50 MHz sys_clk, synchronous active-low reset
// Notes: the hold-off count derives from the times held here; the slew period is given in cycles
package pg_boot_pkg;

    // clock period and the startup hold-off time
    localparam int CLK_PERIOD_NS = 20;
    localparam int HOLD_LOW_US = 20;
    // least time, so round up to whole cycles
    localparam int HOLD_LOW_CYCLES =
        (HOLD_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CNT_W = 10;

    // boot code width (two serial vid pins)
    localparam int BOOT_W = 2;
    localparam logic [BOOT_W-1:0] BOOT_RESET = 2'h0;

    // ramp target counter width for the fixed slew
    localparam int RAMP_W = 8;
    localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;
    localparam logic [RAMP_W-1:0] RAMP_ZERO = 8'h00;
    // slew step period in cycles (fixed rate)
    localparam int SLEW_DIV = 16;
    localparam int SLEW_DIV_W = 4;

    // sequencer states
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RAMP_UP = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b011,
        ST_RAMP_DOWN = 3'b100
    } seq_type;

    // analog comparator results entering the block
    typedef struct packed {
        logic railOneOk;
        logic railTwoOk;
        logic feedbackOk;
        logic belowUpper;
        logic slewActive;
        logic vidDown;
        logic skipMode;
    } sense_type;

endpackage : pg_boot_pkg

// ===== power_good_boot_vid_monitor.sv
// Purpose: power-good supervision, boot code capture and ramp control
// Assumes: comparator inputs are asynchronous to sys_clk
// Notes: power_good_out modelled as drive-low enable; pin is open drain
`timescale 1ns/10ps

// Contract
// (R1) release power good only when both rails ok
// (R2) slew controller active forces power good released
// (R3) after transition, feedback ok keeps release
// (R4) hold power good low 20us after boot
// (R5) capture boot code at first power good
// (R6) rising shutdown input clears stored boot code
// (R7) shutdown drives power good low
// (R8) skip mode blanks upper comparator on downward
// (R9) upper comparator reenabled once back in regulation
// (R10) ramp outputs and reference at fixed slew
// (R11) power good output is drive-low enable
module power_good_boot_vid_monitor (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic shutdown_n_in,
    input wire logic serial_vid_clock,
    input wire logic serial_vid_data,
    input wire pg_boot_pkg::sense_type senseIn,
    output logic power_good_out,
    output logic [pg_boot_pkg::BOOT_W-1:0] bootCode,
    output logic bootValid,
    output logic [pg_boot_pkg::RAMP_W-1:0] rampLevel,
    output logic [pg_boot_pkg::RAMP_W-1:0] buffered_reference_out
);

    ////////////////////////////////////////////////////////////////////////
    // whole module state in one packed struct
    typedef struct packed {
        logic [2:0] shdSync;            // shutdown pin synchroniser
        logic [2:0] clkSync;            // vid clock pin synchroniser
        logic [2:0] datSync;            // vid data pin synchroniser
        logic [6:0] snsSync1;           // comparator stage one
        logic [6:0] snsSync2;           // comparator stage two
        logic [6:0] snsSync3;           // comparator stage three
        logic shdOn;                    // filtered shutdown_n level
        logic [pg_boot_pkg::BOOT_W-1:0] vidOn; // filtered {data, clock}
        logic [6:0] sns;                // filtered comparator levels
        pg_boot_pkg::seq_type seq;      // sequencer state
        logic [pg_boot_pkg::HOLD_CNT_W-1:0] holdCnt; // hold-off counter
        logic [pg_boot_pkg::SLEW_DIV_W-1:0] slewDiv; // slew step divider
        logic [pg_boot_pkg::RAMP_W-1:0] ramp;        // ramp level
        logic upperBlank;               // upper comparator blanked
        logic pgDriveLow;               // drive-low enable
        logic pgSeen;                   // power good has gone high once
        logic [pg_boot_pkg::BOOT_W-1:0] boot; // stored boot code
        logic bootOk;                   // boot code is held
    } state_type;

    state_type cur;
    state_type next_cur;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic shdAgree;
        logic [6:0] snsAgree;
        logic shdRise;
        logic stepNow;
        logic inReg;
        logic upperOk;
        pg_boot_pkg::sense_type s;
        shdAgree = 1'b0;
        snsAgree = 7'h0;
        shdRise = 1'b0;
        stepNow = 1'b0;
        inReg = 1'b0;
        upperOk = 1'b0;
        s = '0;
        next_cur = cur;
        // shift the synchronisers; stage one feeds stage two only
        next_cur.shdSync = {cur.shdSync[1:0], shutdown_n_in};
        next_cur.clkSync = {cur.clkSync[1:0], serial_vid_clock};
        next_cur.datSync = {cur.datSync[1:0], serial_vid_data};
        next_cur.snsSync1 = senseIn;
        next_cur.snsSync2 = cur.snsSync1;
        next_cur.snsSync3 = cur.snsSync2;
        // a change counts once stages two and three agree
        shdAgree = (cur.shdSync[1] == cur.shdSync[2]);
        if (shdAgree) begin
            next_cur.shdOn = cur.shdSync[2];
        end
        // vid pins filtered like the shutdown pin, so a capture never
        // takes a level that is still settling
        if (cur.clkSync[1] == cur.clkSync[2]) begin
            next_cur.vidOn[0] = cur.clkSync[2];
        end
        if (cur.datSync[1] == cur.datSync[2]) begin
            next_cur.vidOn[1] = cur.datSync[2];
        end
        snsAgree = ~(cur.snsSync2 ^ cur.snsSync3);
        next_cur.sns = (snsAgree & cur.snsSync3) | (~snsAgree & cur.sns);
        s = cur.sns;
        shdRise = next_cur.shdOn & ~cur.shdOn;
        // fixed slew step enable from the divider
        next_cur.slewDiv = cur.slewDiv + 4'h1;
        stepNow = (cur.slewDiv == 4'(pg_boot_pkg::SLEW_DIV - 1));
        // upper comparator blanking in skip mode
        if (s.skipMode && s.vidDown) begin
            next_cur.upperBlank = 1'b1; // R8
        end else if (cur.upperBlank && s.railOneOk && s.railTwoOk) begin
            next_cur.upperBlank = 1'b0; // R9
        end
        upperOk = s.belowUpper | cur.upperBlank;
        inReg = s.railOneOk & s.railTwoOk & upperOk;
        // sequencer
        case (cur.seq)
            pg_boot_pkg::ST_OFF: begin
                next_cur.ramp = pg_boot_pkg::RAMP_ZERO;
                if (cur.shdOn) begin
                    next_cur.seq = pg_boot_pkg::ST_RAMP_UP;
                end
            end
            pg_boot_pkg::ST_RAMP_UP: begin
                // top reached: step no further, start the hold-off
                if (cur.ramp == pg_boot_pkg::RAMP_FULL) begin
                    next_cur.seq = pg_boot_pkg::ST_HOLD;
                    next_cur.holdCnt = '0;
                end else if (stepNow) begin
                    next_cur.ramp = cur.ramp + 8'h1; // R10
                end
            end
            pg_boot_pkg::ST_HOLD: begin
                // extra hold-off after reaching boot voltage
                next_cur.holdCnt = cur.holdCnt + 10'h1; // R4
                if (cur.holdCnt == 10'(pg_boot_pkg::HOLD_LOW_CYCLES - 1)) begin
                    next_cur.seq = pg_boot_pkg::ST_RUN;
                end
            end
            pg_boot_pkg::ST_RUN: begin
                next_cur.ramp = pg_boot_pkg::RAMP_FULL;
            end
            pg_boot_pkg::ST_RAMP_DOWN: begin
                // bottom reached: stop stepping so the level cannot wrap
                if (cur.ramp == pg_boot_pkg::RAMP_ZERO) begin
                    next_cur.seq = pg_boot_pkg::ST_OFF;
                end else if (stepNow) begin
                    next_cur.ramp = cur.ramp - 8'h1; // R10
                end
            end
            default: begin
                next_cur.seq = pg_boot_pkg::ST_OFF;
            end
        endcase
        // shutdown overrides: ramp down from any powered state; a ramp
        // already on its way down is left alone so it can reach off
        if (!cur.shdOn && cur.seq != pg_boot_pkg::ST_OFF
            && cur.seq != pg_boot_pkg::ST_RAMP_DOWN) begin
            next_cur.seq = pg_boot_pkg::ST_RAMP_DOWN;
        end
        // power-good drive-low enable
        if (!cur.shdOn || cur.seq == pg_boot_pkg::ST_OFF) begin
            next_cur.pgDriveLow = 1'b1; // R7
        end else if (cur.seq != pg_boot_pkg::ST_RUN) begin
            next_cur.pgDriveLow = 1'b1; // R4
        end else if (s.slewActive) begin
            next_cur.pgDriveLow = 1'b0; // R2
        end else if (cur.pgSeen && s.feedbackOk && s.vidDown) begin
            next_cur.pgDriveLow = 1'b0; // R3
        end else begin
            next_cur.pgDriveLow = ~inReg; // R1
        end
        // boot code capture on first release
        if (!next_cur.pgDriveLow && !cur.pgSeen) begin
            next_cur.pgSeen = 1'b1;
            next_cur.boot = cur.vidOn; // R5
            next_cur.bootOk = 1'b1;
        end
        // rising shutdown_n clears the stored code
        if (shdRise) begin
            next_cur.boot = pg_boot_pkg::BOOT_RESET; // R6
            next_cur.bootOk = 1'b0;
            next_cur.pgSeen = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, synchronous active-low reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur <= '0;
            cur.seq <= pg_boot_pkg::ST_OFF;
            cur.pgDriveLow <= 1'b1;
            cur.boot <= pg_boot_pkg::BOOT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign power_good_out = cur.pgDriveLow; // R11
    assign bootCode = cur.boot;
    assign bootValid = cur.bootOk;
    assign rampLevel = cur.ramp;
    assign buffered_reference_out = cur.ramp;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_shutdown_low; // R7
        @(posedge sys_clk) disable iff (!reset_n)
        !cur.shdOn |=> power_good_out;
    endproperty
    a_shutdown_low: assert property (p_shutdown_low) // R7
        else $error("power good not driven low in shutdown");

    property p_hold_low; // R4
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.seq == pg_boot_pkg::ST_HOLD) |=> power_good_out;
    endproperty
    a_hold_low: assert property (p_hold_low) // R4
        else $error("power good released during hold-off");

    property p_slew_release; // R2
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.shdOn && cur.seq == pg_boot_pkg::ST_RUN && cur.sns[2])
        |=> !power_good_out;
    endproperty
    a_slew_release: assert property (p_slew_release) // R2
        else $error("power good not released while slewing");

    property p_boot_clear; // R6
        @(posedge sys_clk) disable iff (!reset_n)
        (next_cur.shdOn && !cur.shdOn) |=> !bootValid;
    endproperty
    a_boot_clear: assert property (p_boot_clear) // R6
        else $error("boot code not cleared on shutdown release");

    property p_boot_capture; // R5
        @(posedge sys_clk) disable iff (!reset_n)
        ($fell(power_good_out) && !$past(cur.pgSeen)) |-> bootValid;
    endproperty
    a_boot_capture: assert property (p_boot_capture) // R5
        else $error("boot code not captured at first power good");

    property p_boot_stable; // R5
        @(posedge sys_clk) disable iff (!reset_n)
        (bootValid && !(next_cur.shdOn && !cur.shdOn)) |=> $stable(bootCode);
    endproperty
    a_boot_stable: assert property (p_boot_stable) // R5
        else $error("stored boot code changed");

    property p_ramp_step; // R10
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.seq == pg_boot_pkg::ST_RAMP_UP && cur.seq == $past(cur.seq))
        |-> (rampLevel - $past(rampLevel) <= 8'h1);
    endproperty
    a_ramp_step: assert property (p_ramp_step) // R10
        else $error("ramp stepped faster than fixed slew");

    property p_blank_set; // R8
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.sns[0] && cur.sns[1]) |=> cur.upperBlank;
    endproperty
    a_blank_set: assert property (p_blank_set) // R8
        else $error("upper comparator not blanked");

    property p_release_needs_reg; // R1
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.shdOn && cur.seq == pg_boot_pkg::ST_RUN && !cur.sns[2]
         && !cur.sns[1] && !(cur.sns[6] && cur.sns[5]))
        |=> power_good_out;
    endproperty
    a_release_needs_reg: assert property (p_release_needs_reg) // R1
        else $error("power good released out of regulation");

    property p_unblank; // R9
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.upperBlank && !(cur.sns[0] && cur.sns[1])
         && cur.sns[6] && cur.sns[5]) |=> !cur.upperBlank;
    endproperty
    a_unblank: assert property (p_unblank) // R9
        else $error("upper comparator left blanked in regulation");

    property p_feedback_keep; // R3
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.shdOn && cur.seq == pg_boot_pkg::ST_RUN && cur.pgSeen
         && cur.sns[4] && cur.sns[1]) |=> !power_good_out;
    endproperty
    a_feedback_keep: assert property (p_feedback_keep) // R3
        else $error("power good not kept released on feedback ok");

    property p_ramp_down_step; // R10
        @(posedge sys_clk) disable iff (!reset_n)
        (cur.seq == pg_boot_pkg::ST_RAMP_DOWN && cur.seq == $past(cur.seq))
        |-> (rampLevel <= $past(rampLevel)
             && $past(rampLevel) - rampLevel <= 8'h1);
    endproperty
    a_ramp_down_step: assert property (p_ramp_down_step) // R10
        else $error("ramp fell faster than fixed slew or wrapped");

    // hold-off end: last count while powered, then run with the pin low
    sequence s_hold_last;
        cur.shdOn && cur.seq == pg_boot_pkg::ST_HOLD
        && cur.holdCnt == 10'(pg_boot_pkg::HOLD_LOW_CYCLES - 1);
    endsequence
    sequence s_run_still_low;
        cur.seq == pg_boot_pkg::ST_RUN && power_good_out;
    endsequence
    property p_hold_exit; // R4
        @(posedge sys_clk) disable iff (!reset_n)
        s_hold_last |=> s_run_still_low;
    endproperty
    a_hold_exit: assert property (p_hold_exit) // R4
        else $error("hold-off did not end after its count");

endmodule : power_good_boot_vid_monitor

// ===== pg_partner_model.sv
// Purpose: far side of the monitor: rails, comparators and their timing
// Assumes: bench commands comparator levels through cmd
// Notes: rails only read good once the ramp has reached full scale
`timescale 1ns/10ps

module pg_partner_model (
    input wire logic sys_clk,
    input wire logic [pg_boot_pkg::RAMP_W-1:0] rampLevel,
    input wire pg_boot_pkg::sense_type cmd,
    output pg_boot_pkg::sense_type senseIn
);
    // rails cannot be in regulation before the ramp tops out
    pg_boot_pkg::sense_type nextSense;
    logic atTop;

    initial senseIn = '0;

    // comparators change by non-blocking assignment on the edge, so the
    // monitor's first stage takes them one edge later, like slow analog
    always @(posedge sys_clk) begin
        atTop = (rampLevel === pg_boot_pkg::RAMP_FULL);
        nextSense = cmd;
        nextSense.railOneOk = cmd.railOneOk && atTop;
        nextSense.railTwoOk = cmd.railTwoOk && atTop;
        nextSense.feedbackOk = cmd.feedbackOk && atTop;
        senseIn <= nextSense;
    end
endmodule : pg_partner_model

// ===== power_good_boot_vid_monitor_tb_top.sv
// Purpose: self-checking bench for the power-good monitor
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes: output high means the pin is pulled low
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errTotal++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module power_good_boot_vid_monitor_tb_top;
    logic sys_clk, reset_n, shutN, vidClk, vidData, pg, bootValid;
    logic [1:0] bootCode;
    logic [7:0] ramp, refOut;
    pg_boot_pkg::sense_type cmd, senseIn;
    int errTotal = 0;
    int checked = 0;

    power_good_boot_vid_monitor i_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .shutdown_n_in(shutN),
        .serial_vid_clock(vidClk), .serial_vid_data(vidData),
        .senseIn(senseIn), .power_good_out(pg), .bootCode(bootCode),
        .bootValid(bootValid), .rampLevel(ramp),
        .buffered_reference_out(refOut));
    pg_partner_model i_far (.sys_clk(sys_clk), .rampLevel(ramp),
        .cmd(cmd), .senseIn(senseIn));

    ////////////////////////////////////////////////////////////////////
    // clock and watchdog; the run needs about 9.3k cycles
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        errTotal++;
        completeRun();
    end

    task automatic completeRun();
        $display("checks %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : completeRun

    // bounded wait on the power-good drive, then judge it
    task automatic waitPg(input logic e, input int lim, input string nm);
        for (int n = 0; n < lim && pg !== e; n++) @(negedge sys_clk);
        `CHK(nm, e, pg)
    endtask : waitPg

    // bounded wait for a ramp value; returns cycles spent
    task automatic waitRamp(input logic [7:0] v, output int n);
        for (n = 0; n < 5000 && ramp !== v; n++) @(negedge sys_clk);
        `CHK("ramp", v, ramp)
    endtask : waitRamp

    ////////////////////////////////////////////////////////////////////
    // startup: slew step, 20us hold, boot code capture
    task automatic runStartup();
        int n;
        shutN = 1'h1;
        waitRamp(8'h01, n);
        waitRamp(8'h02, n);
        `CHK("slew", pg_boot_pkg::SLEW_DIV, n)
        waitRamp(8'hFF, n);
        `CHK("refout", 8'hFF, refOut)
        `CHK("pghold", 1'h1, pg)
        for (n = 0; n < 1100 && pg !== 1'h0; n++) @(negedge sys_clk);
        `CHK("holdlen", 1'h1, n >= 1000 && n <= 1008)
        `CHK("pgrun", 1'h0, pg)
        `CHK("bootcode", 2'h2, bootCode)
        `CHK("bootvalid", 1'h1, bootValid)
        {vidData, vidClk} = 2'h1;
        repeat (10) @(negedge sys_clk);
        `CHK("bootkeep", 2'h2, bootCode)
    endtask : runStartup

    // one rail out of regulation pulls the pin
    task automatic runRail();
        cmd.railTwoOk = 1'h0;
        waitPg(1'h1, 8, "railbad");
        cmd.railTwoOk = 1'h1;
        waitPg(1'h0, 8, "railok");
    endtask : runRail

    // slew releases regardless; feedback keeps release after it
    task automatic runSlew();
        cmd.railOneOk = 1'h0;
        waitPg(1'h1, 8, "railone");
        cmd.slewActive = 1'h1;
        waitPg(1'h0, 8, "slew");
        cmd.slewActive = 1'h0;
        cmd.vidDown = 1'h1;
        repeat (8) @(negedge sys_clk);
        `CHK("feedback", 1'h0, pg)
        cmd.railOneOk = 1'h1;
        cmd.vidDown = 1'h0;
        repeat (8) @(negedge sys_clk);
        `CHK("restored", 1'h0, pg)
    endtask : runSlew

    // skip mode blanks the upper comparator on a downward step
    task automatic runSkip();
        // feedback low so only the blanking can keep the pin released
        cmd.feedbackOk = 1'h0;
        cmd.skipMode = 1'h1;
        cmd.vidDown = 1'h1;
        repeat (8) @(negedge sys_clk);
        cmd.belowUpper = 1'h0;
        repeat (8) @(negedge sys_clk);
        `CHK("blank", 1'h0, pg)
        cmd.vidDown = 1'h0;
        cmd.belowUpper = 1'h1;
        repeat (8) @(negedge sys_clk);
        cmd.belowUpper = 1'h0;
        waitPg(1'h1, 8, "unblank");
        cmd.belowUpper = 1'h1;
        cmd.skipMode = 1'h0;
        waitPg(1'h0, 8, "skipoff");
        cmd.feedbackOk = 1'h1;
    endtask : runSkip

    // shutdown drives low, ramps down, rising edge clears the code
    task automatic runShutdown();
        int n;
        shutN = 1'h0;
        waitPg(1'h1, 8, "shutdown");
        waitRamp(8'h00, n);
        `CHK("rampdown", 1'h1, n > 4000)
        repeat (20) @(negedge sys_clk);
        `CHK("rampstay", 8'h00, ramp)
        `CHK("pgoff", 1'h1, pg)
        shutN = 1'h1;
        repeat (8) @(negedge sys_clk);
        `CHK("bootclr", 2'h0, bootCode)
        `CHK("validclr", 1'h0, bootValid)
    endtask : runShutdown

    ////////////////////////////////////////////////////////////////////
    // main sequence: reset for three cycles, then every scenario
    initial begin
        reset_n = 1'h0;
        shutN = 1'h0;
        {vidData, vidClk} = 2'h2;
        cmd = 7'h78;
        repeat (3) @(negedge sys_clk);
        `CHK("resetpg", 1'h1, pg)
        reset_n = 1'h1;
        runStartup();
        runRail();
        runSlew();
        runSkip();
        runShutdown();
        completeRun();
    end
endmodule : power_good_boot_vid_monitor_tb_top
